//--- hdl/slc_pkg.sv
// constants and carrier types for the swing, length and count unit
package slc_pkg;
	// clock period and the one millisecond swing time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// percentages are in 0.1 % steps, 1000 means 100.0 %
	localparam logic [25:0] PCT_FULL = 26'h00003E8;
	localparam logic [31:0] PCT_FULL_W = 32'h000003E8;
	// cycle time is in 0.1 s steps, so 100 ms per step
	localparam logic [6:0] MS_PER_STEP = 7'h64;
	// pulses-per-metre is in 0.1 steps
	localparam logic [3:0] PPM_SCALE = 4'hA;
	// largest measured length, 65535 m
	localparam logic [15:0] LEN_MAX = 16'hFFFF;
	// swing configuration word
	typedef struct packed {
		logic base_sel;
		logic [9:0] amp_pct;
		logic [9:0] jump_pct;
		logic [14:0] cycle_time;
		logic [9:0] rise_coeff;
	} slc_swing_cfg_type;
	// frequency limits in 0.01 Hz
	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} slc_limit_type;
	// triangle phase, gray coded along idle, rise, fall
	typedef enum logic [1:0] {
		SLC_IDLE = 2'b00,
		SLC_RISE = 2'b01,
		SLC_FALL = 2'b11
	} slc_phase_type;
endpackage

//--- hdl/slc_unit.sv
// swing frequency generator with fixed-length and count supervision
`timescale 1ns/1ps
module slc_unit
#(
	// cycles per millisecond of swing time base
	parameter int MS_CYCLES = slc_pkg::MS_CYCLES
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic SWING_EN,
	input wire slc_pkg::slc_swing_cfg_type SWING_CFG,
	input wire logic [15:0] CENTRE_FREQ,
	input wire logic [15:0] MAX_OUTPUT_FREQ,
	input wire slc_pkg::slc_limit_type FREQ_LIMIT,
	output logic [15:0] OUTPUT_FREQ,
	output logic [1:0] SWING_PHASE,
	input wire logic LENGTH_PULSE_IN,
	input wire logic LENGTH_RESET_IN,
	input wire logic COUNT_PULSE_IN,
	input wire logic COUNT_CLEAR_IN,
	input wire logic [15:0] TARGET_LENGTH,
	input wire logic [15:0] PULSES_PER_METRE,
	input wire logic [15:0] TERMINAL_COUNT_VALUE,
	input wire logic [15:0] INTERMEDIATE_COUNT_VALUE,
	output logic [15:0] MEASURED_LENGTH,
	output logic LENGTH_REACHED,
	output logic [15:0] COUNT_VALUE,
	output logic TERMINAL_COUNT_REACHED,
	output logic INTERMEDIATE_COUNT_REACHED
);
	// pin synchronisers: bit0 length pulse, bit1 length reset,
	// bit2 count pulse, bit3 count clear
	logic [3:0] pin_meta_r;
	logic [3:0] pin_sync_r;
	logic [3:0] pin_prev_r;
	logic [3:0] pin_raw;
	logic [3:0] pin_rise;

	// swing state
	slc_pkg::slc_phase_type phase_r;
	slc_pkg::slc_phase_type phase_nxt;
	logic [21:0] phase_t_r;
	logic [21:0] phase_t_nxt;
	logic [16:0] ms_cnt_r;
	logic ms_tick;
	logic [15:0] out_freq_r;

	// length and count state
	logic [31:0] pulse_total_r;
	logic [15:0] meas_len_r;
	logic len_reached_r;
	logic [15:0] count_r;
	logic term_reached_r;
	logic inter_reached_r;

	// gather pins into one vector
	assign pin_raw = {COUNT_CLEAR_IN, COUNT_PULSE_IN, LENGTH_RESET_IN, LENGTH_PULSE_IN};

	// two flops per pin, then a third for edge detection
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
			pin_prev_r <= 4'h0;
		end
		else
		begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// one rising-edge strobe per pin, from synchronised stages only
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_edge
			assign pin_rise[gi] = pin_sync_r[gi] & ~pin_prev_r[gi];
		end
	endgenerate

	// ---- swing span and jump step ----

	// amplitude base: centre or maximum frequency
	wire [15:0] span_base = SWING_CFG.base_sel ? MAX_OUTPUT_FREQ : CENTRE_FREQ;
	// span = base times amplitude percent
	wire [25:0] span_prod = span_base * SWING_CFG.amp_pct;
	wire [25:0] span_quot = span_prod / slc_pkg::PCT_FULL;
	wire [15:0] swing_span = span_quot[15:0];
	// jump = span times jump percent
	wire [25:0] jump_prod = swing_span * SWING_CFG.jump_pct;
	wire [25:0] jump_quot = jump_prod / slc_pkg::PCT_FULL;
	wire [15:0] jump_step = jump_quot[15:0];
	// swing only runs when enabled and span is not zero
	wire swing_active = SWING_EN & (swing_span != 16'h0000);

	// ---- segment lengths in milliseconds ----

	// full cycle in ms
	wire [21:0] cycle_ms = SWING_CFG.cycle_time * slc_pkg::MS_PER_STEP;
	// rising part is cycle times coefficient
	wire [31:0] rise_prod = cycle_ms * SWING_CFG.rise_coeff;
	wire [31:0] rise_quot = rise_prod / slc_pkg::PCT_FULL_W;
	wire [21:0] rise_ms = rise_quot[21:0];
	// falling part is the remainder of the cycle
	wire [21:0] fall_ms = cycle_ms - rise_ms;
	// length of the current segment
	wire [21:0] seg_ms = (phase_r == slc_pkg::SLC_FALL) ? fall_ms : rise_ms;
	// segment is over once elapsed time reaches its length
	wire seg_done = (phase_t_r >= seg_ms);

	// ---- triangle value ----

	// travel within a segment is twice the span less the jump
	wire [16:0] ramp_full = {swing_span, 1'b0} - {1'b0, jump_step};
	// linear part: travel times elapsed over segment length
	wire [38:0] ramp_prod = ramp_full * phase_t_r;
	wire [38:0] ramp_div = (seg_ms == 22'h000000) ? 39'h0000000001 : {17'h00000, seg_ms};
	wire [38:0] ramp_quot = ramp_prod / ramp_div;
	wire [16:0] ramp_part = seg_done ? ramp_full : ramp_quot[16:0];
	// signed forms for the frequency arithmetic
	wire signed [18:0] centre_s = {3'b000, CENTRE_FREQ};
	wire signed [18:0] span_s = {3'b000, swing_span};
	wire signed [18:0] jump_s = {3'b000, jump_step};
	wire signed [18:0] ramp_s = {2'b00, ramp_part};
	// rising starts at centre-span+jump and ends at centre+span
	wire signed [18:0] rise_val = centre_s - span_s + jump_s + ramp_s;
	// falling starts at centre+span-jump and ends at centre-span
	wire signed [18:0] fall_val = centre_s + span_s - jump_s - ramp_s;
	// no swing: output sits on the centre frequency
	wire signed [18:0] raw_val = (phase_r == slc_pkg::SLC_RISE) ? rise_val :
		(phase_r == slc_pkg::SLC_FALL) ? fall_val : centre_s;
	// limits in signed form
	wire signed [18:0] upper_s = {3'b000, FREQ_LIMIT.upper};
	wire signed [18:0] lower_s = {3'b000, FREQ_LIMIT.lower};
	// clamp into the limits, upper limit wins if they cross
	wire signed [18:0] clamp_lo = (raw_val < lower_s) ? lower_s : raw_val;
	wire signed [18:0] clamp_val = (clamp_lo > upper_s) ? upper_s : clamp_lo;

	// ---- millisecond time base ----

	// tick once per millisecond
	assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

	// free-running ms prescaler
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			ms_cnt_r <= 17'h00000;
		end
		else if (ms_tick)
		begin
			ms_cnt_r <= 17'h00000;
		end
		else
		begin
			ms_cnt_r <= ms_cnt_r + 17'h00001;
		end
	end

	// ---- triangle sequencing ----

	// next phase and elapsed time
	always_comb
	begin
		phase_nxt = phase_r;
		phase_t_nxt = phase_t_r;
		case (phase_r)
			slc_pkg::SLC_IDLE:
			begin
				// start a fresh cycle on the rising segment
				phase_t_nxt = 22'h000000;
				if (swing_active)
				begin
					phase_nxt = slc_pkg::SLC_RISE;
				end
			end
			slc_pkg::SLC_RISE:
			begin
				if (!swing_active)
				begin
					// swing stopped, go back to centre
					phase_nxt = slc_pkg::SLC_IDLE;
					phase_t_nxt = 22'h000000;
				end
				else if (seg_done)
				begin
					// rising part complete, turn down
					phase_nxt = slc_pkg::SLC_FALL;
					phase_t_nxt = 22'h000000;
				end
				else if (ms_tick)
				begin
					// one more millisecond elapsed
					phase_t_nxt = phase_t_r + 22'h000001;
				end
			end
			slc_pkg::SLC_FALL:
			begin
				if (!swing_active)
				begin
					// swing stopped, go back to centre
					phase_nxt = slc_pkg::SLC_IDLE;
					phase_t_nxt = 22'h000000;
				end
				else if (seg_done)
				begin
					// falling part complete, next cycle at once
					phase_nxt = slc_pkg::SLC_RISE;
					phase_t_nxt = 22'h000000;
				end
				else if (ms_tick)
				begin
					// one more millisecond elapsed
					phase_t_nxt = phase_t_r + 22'h000001;
				end
			end
			default:
			begin
				// recover from an illegal code
				phase_nxt = slc_pkg::SLC_IDLE;
				phase_t_nxt = 22'h000000;
			end
		endcase
	end

	// phase registers
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			phase_r <= slc_pkg::SLC_IDLE;
			phase_t_r <= 22'h000000;
		end
		else
		begin
			phase_r <= phase_nxt;
			phase_t_r <= phase_t_nxt;
		end
	end

	// registered output frequency
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			out_freq_r <= 16'h0000;
		end
		else
		begin
			out_freq_r <= clamp_val[15:0];
		end
	end

	// ---- length measurement ----

	// length = pulses times ten over pulses-per-metre
	wire [35:0] len_prod = pulse_total_r * slc_pkg::PPM_SCALE;
	wire [35:0] len_div = {20'h00000, PULSES_PER_METRE};
	wire [35:0] len_quot = (PULSES_PER_METRE == 16'h0000) ? 36'h000000000 : len_prod / len_div;
	// saturate at the largest length
	wire [15:0] len_sat = (len_quot > {20'h00000, slc_pkg::LEN_MAX}) ? slc_pkg::LEN_MAX :
		len_quot[15:0];
	// length pulse strobe and reset level from the terminals
	wire len_pulse = pin_rise[0];
	wire len_clear = pin_sync_r[1];
	wire pulse_sat = (pulse_total_r == 32'hFFFFFFFF);

	// pulse total, cleared while reset terminal is on
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			pulse_total_r <= 32'h00000000;
		end
		else if (len_clear)
		begin
			pulse_total_r <= 32'h00000000;
		end
		else if (len_pulse && !pulse_sat)
		begin
			pulse_total_r <= pulse_total_r + 32'h00000001;
		end
	end

	// measured length and reached flag
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			meas_len_r <= 16'h0000;
			len_reached_r <= 1'b0;
		end
		else
		begin
			meas_len_r <= len_sat;
			len_reached_r <= (len_sat > TARGET_LENGTH);
		end
	end

	// ---- pulse counter ----

	// count pulse strobe and clear level
	wire cnt_pulse = pin_rise[2];
	wire cnt_clear = pin_sync_r[3];
	// counting halts once the terminal value is reached
	wire cnt_halt = (count_r >= TERMINAL_COUNT_VALUE);
	// comparisons on the value about to be stored
	wire [15:0] count_nxt = cnt_clear ? 16'h0000 :
		(cnt_pulse && !cnt_halt) ? count_r + 16'h0001 : count_r;

	// count and its reached flags
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			count_r <= 16'h0000;
			term_reached_r <= 1'b0;
			inter_reached_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			term_reached_r <= (count_nxt >= TERMINAL_COUNT_VALUE);
			// keeps counting past this, for ordering
			inter_reached_r <= (count_nxt >= INTERMEDIATE_COUNT_VALUE);
		end
	end

	// ---- outputs ----
	assign OUTPUT_FREQ = out_freq_r;
	assign SWING_PHASE = phase_r;
	assign MEASURED_LENGTH = meas_len_r;
	assign LENGTH_REACHED = len_reached_r;
	assign COUNT_VALUE = count_r;
	assign TERMINAL_COUNT_REACHED = term_reached_r;
	assign INTERMEDIATE_COUNT_REACHED = inter_reached_r;
endmodule

//--- verification/slc_unit_sva.sv
// assertion checker for the swing, length and count unit
`timescale 1ns/1ps
module slc_unit_sva
#(
	parameter int MS_CYCLES = 10
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic SWING_EN,
	input wire slc_pkg::slc_swing_cfg_type SWING_CFG,
	input wire logic [15:0] CENTRE_FREQ,
	input wire slc_pkg::slc_limit_type FREQ_LIMIT,
	input wire logic [15:0] OUTPUT_FREQ,
	input wire logic [1:0] SWING_PHASE,
	input wire logic LENGTH_RESET_IN,
	input wire logic COUNT_CLEAR_IN,
	input wire logic [15:0] TARGET_LENGTH,
	input wire logic [15:0] TERMINAL_COUNT_VALUE,
	input wire logic [15:0] INTERMEDIATE_COUNT_VALUE,
	input wire logic [15:0] MEASURED_LENGTH,
	input wire logic LENGTH_REACHED,
	input wire logic [15:0] COUNT_VALUE,
	input wire logic TERMINAL_COUNT_REACHED,
	input wire logic INTERMEDIATE_COUNT_REACHED
);
	// clamp into the limit window, upper limit wins a conflict
	function automatic logic [15:0] lim_f(logic [15:0] v, slc_pkg::slc_limit_type l);
		logic [15:0] lo_v;
		lo_v = (v < l.lower) ? l.lower : v;
		return (lo_v > l.upper) ? l.upper : lo_v;
	endfunction
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// clear pin quiet long enough to have left the synchroniser
	sequence no_clr_s;
		!COUNT_CLEAR_IN [*4];
	endsequence
	// end of a falling segment while swing stays active
	sequence fall_end_s;
		(SWING_PHASE == 2'b11 && SWING_EN && SWING_CFG.amp_pct != 10'h000)
			##1 (SWING_PHASE != 2'b11);
	endsequence
	chk_len_clear: assert property (LENGTH_RESET_IN [*5] |=>
		MEASURED_LENGTH == 16'h0000 && !LENGTH_REACHED)
		else $error("length not cleared by reset terminal");
	chk_len_flag: assert property ($stable(TARGET_LENGTH) && !$past(RST) |->
		LENGTH_REACHED == (MEASURED_LENGTH > TARGET_LENGTH))
		else $error("length reached flag wrong");
	chk_term_flag: assert property ($stable(TERMINAL_COUNT_VALUE) && !$past(RST) |->
		TERMINAL_COUNT_REACHED == (COUNT_VALUE >= TERMINAL_COUNT_VALUE))
		else $error("terminal count flag wrong");
	chk_mid_flag: assert property (
		$stable(INTERMEDIATE_COUNT_VALUE) && !$past(RST) |->
		INTERMEDIATE_COUNT_REACHED == (COUNT_VALUE >= INTERMEDIATE_COUNT_VALUE))
		else $error("intermediate count flag wrong");
	chk_count_halt: assert property (
		(no_clr_s ##0 TERMINAL_COUNT_REACHED && $stable(TERMINAL_COUNT_VALUE)) |=>
		$stable(COUNT_VALUE))
		else $error("count moved after terminal value");
	chk_idle_freq: assert property (
		(!SWING_EN && $stable(CENTRE_FREQ) && $stable(FREQ_LIMIT)) [*3] |->
		OUTPUT_FREQ == lim_f(CENTRE_FREQ, FREQ_LIMIT) && SWING_PHASE == 2'b00)
		else $error("idle output not clamped centre");
	chk_amp_zero: assert property (SWING_CFG.amp_pct == 10'h000 |=> SWING_PHASE == 2'b00)
		else $error("swing runs with zero amplitude");
	chk_out_clamp: assert property (!$past(RST) && $stable(FREQ_LIMIT) |->
		OUTPUT_FREQ <= FREQ_LIMIT.upper &&
		(OUTPUT_FREQ >= FREQ_LIMIT.lower || OUTPUT_FREQ == FREQ_LIMIT.upper))
		else $error("output outside limits");
	chk_fall_rise: assert property (fall_end_s |-> SWING_PHASE == 2'b01)
		else $error("fall not followed by rise");
	chk_idle_rise: assert property (SWING_PHASE == 2'b00 |=> SWING_PHASE != 2'b11)
		else $error("swing left idle into fall");
endmodule
bind slc_unit slc_unit_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (.CLK(CLK), .RST(RST),
	.SWING_EN(SWING_EN), .SWING_CFG(SWING_CFG), .CENTRE_FREQ(CENTRE_FREQ),
	.FREQ_LIMIT(FREQ_LIMIT), .OUTPUT_FREQ(OUTPUT_FREQ), .SWING_PHASE(SWING_PHASE),
	.LENGTH_RESET_IN(LENGTH_RESET_IN), .COUNT_CLEAR_IN(COUNT_CLEAR_IN),
	.TARGET_LENGTH(TARGET_LENGTH), .TERMINAL_COUNT_VALUE(TERMINAL_COUNT_VALUE),
	.INTERMEDIATE_COUNT_VALUE(INTERMEDIATE_COUNT_VALUE), .MEASURED_LENGTH(MEASURED_LENGTH),
	.LENGTH_REACHED(LENGTH_REACHED), .COUNT_VALUE(COUNT_VALUE),
	.TERMINAL_COUNT_REACHED(TERMINAL_COUNT_REACHED),
	.INTERMEDIATE_COUNT_REACHED(INTERMEDIATE_COUNT_REACHED));

//--- verification/slc_pin_model.sv
// terminal model making length and count pulses and clear levels
`timescale 1ns/1ps
module slc_pin_model
(
	input wire logic clk,
	output logic len_pulse,
	output logic len_clear,
	output logic cnt_pulse,
	output logic cnt_clear
);
	// all terminals rest low
	initial
	begin
		len_pulse = 1'b0;
		len_clear = 1'b0;
		cnt_pulse = 1'b0;
		cnt_clear = 1'b0;
	end
	// n pulses, two clocks high and two low; sel 0 length, 1 count
	task automatic send(input logic sel, input int n);
		repeat (n)
		begin
			@(negedge clk);
			cnt_pulse = sel;
			len_pulse = !sel;
			repeat (2) @(negedge clk);
			cnt_pulse = 1'b0;
			len_pulse = 1'b0;
			@(negedge clk);
		end
	endtask
	// clear level held six clocks
	task automatic clear(input logic sel);
		@(negedge clk);
		cnt_clear = sel;
		len_clear = !sel;
		repeat (6) @(negedge clk);
		cnt_clear = 1'b0;
		len_clear = 1'b0;
	endtask
endmodule

//--- verification/slc_unit_tb.sv
// self-checking bench for the swing, length and count unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module slc_unit_tb;
	logic CLK, RST, SWING_EN, lp, lc, cp, cc;
	logic LENGTH_REACHED, TERMINAL_COUNT_REACHED, INTERMEDIATE_COUNT_REACHED;
	slc_pkg::slc_swing_cfg_type SWING_CFG;
	slc_pkg::slc_limit_type FREQ_LIMIT;
	logic [15:0] CENTRE_FREQ, MAX_OUTPUT_FREQ, OUTPUT_FREQ, MEASURED_LENGTH, COUNT_VALUE;
	// length and count settings, driven by the bench so they can be moved
	logic [15:0] TARGET_LENGTH, PULSES_PER_METRE, TERMINAL_COUNT_VALUE, INTERMEDIATE_COUNT_VALUE;
	logic [1:0] SWING_PHASE;
	int err_count, n_compared, cyc, n;
	slc_unit #(.MS_CYCLES(10)) dut_u (.CLK(CLK), .RST(RST), .SWING_EN(SWING_EN),
		.SWING_CFG(SWING_CFG), .CENTRE_FREQ(CENTRE_FREQ), .MAX_OUTPUT_FREQ(MAX_OUTPUT_FREQ),
		.FREQ_LIMIT(FREQ_LIMIT), .OUTPUT_FREQ(OUTPUT_FREQ), .SWING_PHASE(SWING_PHASE),
		.LENGTH_PULSE_IN(lp), .LENGTH_RESET_IN(lc), .COUNT_PULSE_IN(cp), .COUNT_CLEAR_IN(cc),
		.TARGET_LENGTH(TARGET_LENGTH), .PULSES_PER_METRE(PULSES_PER_METRE),
		.TERMINAL_COUNT_VALUE(TERMINAL_COUNT_VALUE),
		.INTERMEDIATE_COUNT_VALUE(INTERMEDIATE_COUNT_VALUE),
		.MEASURED_LENGTH(MEASURED_LENGTH), .LENGTH_REACHED(LENGTH_REACHED),
		.COUNT_VALUE(COUNT_VALUE),
		.TERMINAL_COUNT_REACHED(TERMINAL_COUNT_REACHED),
		.INTERMEDIATE_COUNT_REACHED(INTERMEDIATE_COUNT_REACHED));
	slc_pin_model pin_u (.clk(CLK), .len_pulse(lp), .len_clear(lc), .cnt_pulse(cp), .cnt_clear(cc));
	// verdict and end of run
	task automatic finish_test();
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// wait at falling edges for a swing phase, counting the cycles
	task automatic wait_ph(input logic [1:0] ph);
		n = 0;
		while (SWING_PHASE !== ph && n < 3000)
		begin
			@(negedge CLK);
			n++;
		end
	endtask
	// let pulses cross the synchroniser, then compare pin outputs
	task automatic pins(input logic [15:0] len, input logic lr, input logic [15:0] cnt, input logic mid,
		input logic term);
		repeat (6) @(negedge CLK);
		`CHK("length", len, MEASURED_LENGTH)
		`CHK("len_reached", lr, LENGTH_REACHED)
		`CHK("count", cnt, COUNT_VALUE)
		`CHK("mid_flag", mid, INTERMEDIATE_COUNT_REACHED)
		`CHK("term_flag", term, TERMINAL_COUNT_REACHED)
	endtask
	// clock
	always #5 CLK = ~CLK;
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			finish_test();
		end
	end
	// main sequence: centre 5000, max 8000, limits 4400..5600
	initial
	begin
		CLK = 1'b0;
		RST = 1'b1;
		SWING_EN = 1'b1;
		SWING_CFG = '{1'b0, 10'h064, 10'h064, 15'h0001, 10'h12C};
		CENTRE_FREQ = 16'h1388;
		MAX_OUTPUT_FREQ = 16'h1F40;
		FREQ_LIMIT = '{16'h15E0, 16'h1130};
		TARGET_LENGTH = 16'h0004;
		PULSES_PER_METRE = 16'h0014;
		TERMINAL_COUNT_VALUE = 16'h0005;
		INTERMEDIATE_COUNT_VALUE = 16'h0003;
		repeat (6) @(negedge CLK);
		RST = 1'b0;
		wait_ph(2'b01);
		@(negedge CLK);
		`CHK("rise_start", 16'h11C6, OUTPUT_FREQ)
		wait_ph(2'b11);
		`CHK("rise_time", 1'b1, (n >= 285 && n <= 315))
		@(negedge CLK);
		`CHK("peak", 16'h154A, OUTPUT_FREQ)
		wait_ph(2'b01);
		`CHK("fall_time", 1'b1, (n >= 685 && n <= 715))
		SWING_CFG.base_sel = 1'b1;
		wait_ph(2'b11);
		@(negedge CLK);
		`CHK("peak_max", 16'h15E0, OUTPUT_FREQ)
		wait_ph(2'b01);
		@(negedge CLK);
		`CHK("low_max", 16'h1130, OUTPUT_FREQ)
		// swing off with the centre above the upper limit
		SWING_EN = 1'b0;
		CENTRE_FREQ = 16'h1770;
		repeat (4) @(negedge CLK);
		`CHK("idle_clamp", 16'h15E0, OUTPUT_FREQ)
		`CHK("idle_phase", 2'b00, SWING_PHASE)
		CENTRE_FREQ = 16'h1388;
		SWING_EN = 1'b1;
		SWING_CFG.amp_pct = 10'h000;
		repeat (4) @(negedge CLK);
		`CHK("no_swing", 16'h1388, OUTPUT_FREQ)
		pin_u.send(1'b0, 8);
		pins(16'h0004, 1'b0, 16'h0000, 1'b0, 1'b0);
		pin_u.send(1'b0, 2);
		pins(16'h0005, 1'b1, 16'h0000, 1'b0, 1'b0);
		// equal to the target is not yet beyond it
		TARGET_LENGTH = 16'h0005;
		pins(16'h0005, 1'b0, 16'h0000, 1'b0, 1'b0);
		pin_u.clear(1'b0);
		pins(16'h0000, 1'b0, 16'h0000, 1'b0, 1'b0);
		pin_u.send(1'b1, 3);
		pins(16'h0000, 1'b0, 16'h0003, 1'b1, 1'b0);
		pin_u.send(1'b1, 4);
		pins(16'h0000, 1'b0, 16'h0005, 1'b1, 1'b1);
		pin_u.clear(1'b1);
		pins(16'h0000, 1'b0, 16'h0000, 1'b0, 1'b0);
		finish_test();
	end
endmodule
